// file: design/memi_pkg.sv
// Constants and carrier types for the metering event interrupt mask block
package memi_pkg;
  ////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_ENABLE = 16'hE50B;
  localparam logic [15:0] IDX_PHASE = 16'hE600;
  localparam logic [15:0] IDX_FLAGS = 16'hE510;
  localparam logic [15:0] IDX_LIMIT = 16'hE511;
  ////////////////////////////////////////////////////////////////////////
  // Bit positions shared by enable and flag registers
  localparam int unsigned BIT_NOLOAD_TOT = 0;
  localparam int unsigned BIT_NOLOAD_FUND = 1;
  localparam int unsigned BIT_NOLOAD_APP = 2;
  localparam int unsigned LSB_MISS_VOLT = 3;
  localparam int unsigned LSB_MISS_CURR = 6;
  localparam int unsigned LSB_CROSS_VOLT = 9;
  localparam int unsigned LSB_CROSS_CURR = 12;
  localparam int unsigned BIT_INIT_DONE = 15;
  localparam int unsigned BIT_DIP = 16;
  localparam int unsigned BIT_EXC_CURR = 17;
  localparam int unsigned BIT_EXC_VOLT = 18;
  localparam int unsigned BIT_ORDER = 19;
  localparam int unsigned BIT_NEUTRAL = 20;
  localparam int unsigned BIT_PEAK_CURR = 23;
  localparam int unsigned BIT_PEAK_VOLT = 24;
  // Phase source field positions
  localparam int unsigned PH_EXC_CURR_LSB = 3;
  localparam int unsigned PH_EXC_VOLT_LSB = 9;
  localparam int unsigned PH_DIP_LSB = 12;
  ////////////////////////////////////////////////////////////////////////
  // Masks and reset values
  localparam logic [31:0] ENABLE_MASK = 32'h019F_FFFF;
  localparam logic [31:0] ALWAYS_ON = 32'h0000_8000;
  localparam logic [15:0] PHASE_MASK = 16'h7E38;
  localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
  localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;
  localparam logic [15:0] PHASE_RESET = 16'h0000;
  localparam logic [23:0] LIMIT_RESET = 24'h00_0000;
  ////////////////////////////////////////////////////////////////////////
  // Carrier types
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } memi_apb_req_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } memi_apb_rsp_t;
  typedef struct packed {
    logic noload_total;
    logic noload_fund;
    logic noload_app;
    logic [2:0] miss_volt;
    logic [2:0] miss_curr;
    logic [2:0] cross_volt;
    logic [2:0] cross_curr;
    logic init_complete;
    logic [2:0] dip;
    logic [2:0] exc_curr;
    logic [2:0] exc_volt;
    logic [2:0] volt_rise;
    logic peak_curr_end;
    logic peak_volt_end;
  } memi_events_t;
  typedef struct packed {
    logic valid;
    logic signed [27:0] sum_curr;
    logic signed [27:0] neutral;
  } memi_neutral_t;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_AFTER_A} memi_seq_state_t;
endpackage

// file: design/memi_top.sv
// Event flag, enable mask and interrupt logic for the second event group
// Overview of operation
// - Enable bit 0 passes the total-power no-load event to the interrupt.
// - Enable bit 1 passes fundamental no-load; ignored without fundamental option.
// - Enable bit 2 passes the apparent-power no-load event.
// - Enable bits 3..5 pass missing voltage crossing of phases A, B, C.
// - Enable bits 6..8 pass missing current crossing of phases A, B, C.
// - Enable bits 9..11 pass detected voltage crossings of phases A, B, C.
// - Enable bits 12..14 pass detected current crossings of phases A, B, C.
// - Enable bit 15 stores freely but init-complete interrupt always passes.
// - Enable bit 16 passes voltage dip on phases recorded in bits 14..12.
// - Enable bit 17 passes overcurrent on phases recorded in bits 5..3.
// - Enable bit 18 passes overvoltage on phases recorded in bits 11..9.
// - Enable bit 19 passes phase order fault: rising A then C before B.
// - Enable bit 20 passes neutral mismatch above limit; ignored without neutral.
// - Enable bits 22..21 and 31..25 read zero and steer nothing.
// - Enable bit 23 passes end of current peak-detection period.
// - Enable bit 24 passes end of voltage peak-detection period.
// - Phase source bits 2..0 always read zero.
// - Phase source bits 3..5 mark which phase current caused overcurrent.
// - Phase source bits 9..11 mark which phase voltage caused overvoltage.
`timescale 1ns/1ps
module memi_top #(
  parameter bit HAS_FUNDAMENTAL = 1'b1,
  parameter bit HAS_NEUTRAL = 1'b1
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // APB slave
  input wire memi_pkg::memi_apb_req_t i_apb,
  output memi_pkg::memi_apb_rsp_t o_apb,
  // Measurement events, one-cycle pulses
  input wire memi_pkg::memi_events_t i_events,
  input wire memi_pkg::memi_neutral_t i_neutral,
  // Interrupt to host
  output logic o_irq_n
);

  ////////////////////////////////////////////////////////////////////////
  // Address decode
  logic [31:0] addr_enable;
  logic [31:0] addr_phase;
  logic [31:0] addr_flags;
  logic [31:0] addr_limit;
  logic hit_enable;
  logic hit_phase;
  logic hit_flags;
  logic hit_limit;
  logic hit_any;
  logic setup_phase;
  logic access_done;
  logic wr_enable;
  logic wr_flags;
  logic wr_limit;

  assign addr_enable = {14'h0000, memi_pkg::IDX_ENABLE, 2'h0};
  assign addr_phase = {14'h0000, memi_pkg::IDX_PHASE, 2'h0};
  assign addr_flags = {14'h0000, memi_pkg::IDX_FLAGS, 2'h0};
  assign addr_limit = {14'h0000, memi_pkg::IDX_LIMIT, 2'h0};
  assign hit_enable = (i_apb.paddr == addr_enable);
  assign hit_phase = (i_apb.paddr == addr_phase);
  assign hit_flags = (i_apb.paddr == addr_flags);
  assign hit_limit = (i_apb.paddr == addr_limit);
  assign hit_any = hit_enable | hit_phase | hit_flags | hit_limit;
  assign setup_phase = i_apb.psel & ~i_apb.penable;
  assign access_done = i_apb.psel & i_apb.penable & o_apb.pready;
  assign wr_enable = access_done & i_apb.pwrite & hit_enable;
  assign wr_flags = access_done & i_apb.pwrite & hit_flags;
  assign wr_limit = access_done & i_apb.pwrite & hit_limit;

  ////////////////////////////////////////////////////////////////////////
  // Software registers: enable mask and mismatch limit
  logic [31:0] enable_ff;
  logic [31:0] nxt_enable;
  logic [23:0] limit_ff;
  logic [23:0] nxt_limit;

  always_comb begin
    nxt_enable = enable_ff;
    nxt_limit = limit_ff;
    if (wr_enable) begin
      // Bit 15 is stored like any other
      nxt_enable = i_apb.pwdata & memi_pkg::ENABLE_MASK;
    end
    if (wr_limit) begin
      nxt_limit = i_apb.pwdata[23:0];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      enable_ff <= memi_pkg::ENABLE_RESET;
      limit_ff <= memi_pkg::LIMIT_RESET;
    end else begin
      enable_ff <= nxt_enable;
      limit_ff <= nxt_limit;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Phase order watcher on rising voltage crossings
  memi_pkg::memi_seq_state_t seq_state_ff;
  memi_pkg::memi_seq_state_t nxt_seq_state;
  logic order_fault_ff;
  logic nxt_order_fault;

  always_comb begin
    nxt_seq_state = seq_state_ff;
    nxt_order_fault = 1'b0;
    unique case (seq_state_ff)
      memi_pkg::SEQ_IDLE: begin
        if (i_events.volt_rise[0]) begin
          nxt_seq_state = memi_pkg::SEQ_AFTER_A;
        end
      end
      memi_pkg::SEQ_AFTER_A: begin
        // B wins if B and C rise together
        if (i_events.volt_rise[1]) begin
          nxt_seq_state = memi_pkg::SEQ_IDLE;
        end else if (i_events.volt_rise[2]) begin
          nxt_order_fault = 1'b1;
          nxt_seq_state = memi_pkg::SEQ_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      seq_state_ff <= memi_pkg::SEQ_IDLE;
      order_fault_ff <= 1'b0;
    end else begin
      seq_state_ff <= nxt_seq_state;
      order_fault_ff <= nxt_order_fault;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Neutral current mismatch check
  logic [27:0] mag_sum;
  logic [27:0] mag_neutral;
  logic [27:0] mag_diff;
  logic mismatch_ff;
  logic nxt_mismatch;

  always_comb begin
    mag_sum = i_neutral.sum_curr[27] ? 28'(-i_neutral.sum_curr) : 28'(i_neutral.sum_curr);
    mag_neutral = i_neutral.neutral[27] ? 28'(-i_neutral.neutral) : 28'(i_neutral.neutral);
    if (mag_sum >= mag_neutral) begin
      mag_diff = 28'(mag_sum - mag_neutral);
    end else begin
      mag_diff = 28'(mag_neutral - mag_sum);
    end
    nxt_mismatch = HAS_NEUTRAL & i_neutral.valid & (mag_diff > {4'h0, limit_ff});
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      mismatch_ff <= 1'b0;
    end else begin
      mismatch_ff <= nxt_mismatch;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky event flags and phase sources, write one to clear, set wins
  logic [31:0] flags_ff;
  logic [31:0] nxt_flags;
  logic [31:0] flag_set;
  logic [31:0] flag_clr;
  logic [15:0] phase_ff;
  logic [15:0] nxt_phase;
  logic [15:0] phase_set;
  logic [15:0] phase_clr;

  always_comb begin
    flag_set = 32'h0000_0000;
    flag_set[memi_pkg::BIT_NOLOAD_TOT] = i_events.noload_total;
    flag_set[memi_pkg::BIT_NOLOAD_FUND] = HAS_FUNDAMENTAL & i_events.noload_fund;
    flag_set[memi_pkg::BIT_NOLOAD_APP] = i_events.noload_app;
    flag_set[memi_pkg::BIT_INIT_DONE] = i_events.init_complete;
    flag_set[memi_pkg::BIT_DIP] = |i_events.dip;
    flag_set[memi_pkg::BIT_EXC_CURR] = |i_events.exc_curr;
    flag_set[memi_pkg::BIT_EXC_VOLT] = |i_events.exc_volt;
    flag_set[memi_pkg::BIT_ORDER] = order_fault_ff;
    flag_set[memi_pkg::BIT_NEUTRAL] = mismatch_ff;
    flag_set[memi_pkg::BIT_PEAK_CURR] = i_events.peak_curr_end;
    flag_set[memi_pkg::BIT_PEAK_VOLT] = i_events.peak_volt_end;
    for (int p = 0; p < 3; p++) begin
      flag_set[memi_pkg::LSB_MISS_VOLT + p] = i_events.miss_volt[p];
      flag_set[memi_pkg::LSB_MISS_CURR + p] = i_events.miss_curr[p];
      flag_set[memi_pkg::LSB_CROSS_VOLT + p] = i_events.cross_volt[p];
      flag_set[memi_pkg::LSB_CROSS_CURR + p] = i_events.cross_curr[p];
    end
    flag_clr = wr_flags ? i_apb.pwdata : 32'h0000_0000;
    nxt_flags = ((flags_ff & ~flag_clr) | flag_set) & memi_pkg::ENABLE_MASK;
  end

  always_comb begin
    phase_set = 16'h0000;
    phase_clr = 16'h0000;
    for (int p = 0; p < 3; p++) begin
      phase_set[memi_pkg::PH_EXC_CURR_LSB + p] = i_events.exc_curr[p];
      phase_set[memi_pkg::PH_EXC_VOLT_LSB + p] = i_events.exc_volt[p];
      phase_set[memi_pkg::PH_DIP_LSB + p] = i_events.dip[p];
      // Clearing a flag also clears its phase record
      phase_clr[memi_pkg::PH_EXC_CURR_LSB + p] = flag_clr[memi_pkg::BIT_EXC_CURR];
      phase_clr[memi_pkg::PH_EXC_VOLT_LSB + p] = flag_clr[memi_pkg::BIT_EXC_VOLT];
      phase_clr[memi_pkg::PH_DIP_LSB + p] = flag_clr[memi_pkg::BIT_DIP];
    end
    nxt_phase = ((phase_ff & ~phase_clr) | phase_set) & memi_pkg::PHASE_MASK;
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      flags_ff <= memi_pkg::FLAGS_RESET;
      phase_ff <= memi_pkg::PHASE_RESET;
    end else begin
      flags_ff <= nxt_flags;
      phase_ff <= nxt_phase;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt output, active low level
  logic [31:0] eff_enable;
  logic irq_n_ff;
  logic nxt_irq_n;

  always_comb begin
    eff_enable = enable_ff;
    eff_enable[memi_pkg::BIT_INIT_DONE] = 1'b0;
    eff_enable = eff_enable | memi_pkg::ALWAYS_ON;
    if (!HAS_FUNDAMENTAL) begin
      eff_enable[memi_pkg::BIT_NOLOAD_FUND] = 1'b0;
    end
    if (!HAS_NEUTRAL) begin
      eff_enable[memi_pkg::BIT_NEUTRAL] = 1'b0;
    end
    eff_enable = eff_enable & memi_pkg::ENABLE_MASK;
    nxt_irq_n = ~|(nxt_flags & eff_enable);
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_n_ff <= 1'b1;
    end else begin
      irq_n_ff <= nxt_irq_n;
    end
  end

  assign o_irq_n = irq_n_ff;

  ////////////////////////////////////////////////////////////////////////
  // APB answer, prepared in the setup cycle
  memi_pkg::memi_apb_rsp_t rsp_ff;
  memi_pkg::memi_apb_rsp_t nxt_rsp;

  always_comb begin
    nxt_rsp = '0;
    if (setup_phase) begin
      nxt_rsp.pready = 1'b1;
      nxt_rsp.pslverr = ~hit_any;
      if (!i_apb.pwrite) begin
        unique case (1'b1)
          hit_enable: nxt_rsp.prdata = enable_ff;
          hit_phase: nxt_rsp.prdata = {16'h0000, phase_ff};
          hit_flags: nxt_rsp.prdata = flags_ff;
          hit_limit: nxt_rsp.prdata = {8'h00, limit_ff};
          default: nxt_rsp.prdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff <= nxt_rsp;
    end
  end

  assign o_apb = rsp_ff;

endmodule // memi_top

// file: tb/memi_sva.sv
// Checker for bus timing and interrupt masking of the event mask block
`timescale 1ns/1ps
module memi_sva (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // Watched ports
  input wire memi_pkg::memi_apb_req_t i_apb,
  input wire memi_pkg::memi_apb_rsp_t o_apb,
  input wire memi_pkg::memi_events_t i_events,
  input wire memi_pkg::memi_neutral_t i_neutral,
  input wire logic o_irq_n
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  logic [31:0] en_ff, nxt_en, ev;
  logic wr_ack, rd_en, rd_ph;
  assign wr_ack = o_apb.pready && i_apb.pwrite;
  assign rd_en = o_apb.pready && !i_apb.pwrite && i_apb.paddr == {14'h0000, memi_pkg::IDX_ENABLE, 2'h0};
  assign rd_ph = o_apb.pready && !i_apb.pwrite && i_apb.paddr == {14'h0000, memi_pkg::IDX_PHASE, 2'h0};
  assign ev = {7'h00, i_events.peak_volt_end, i_events.peak_curr_end, 4'h0, |i_events.exc_volt,
    |i_events.exc_curr, |i_events.dip, i_events.init_complete, i_events.cross_curr, i_events.cross_volt,
    i_events.miss_curr, i_events.miss_volt, i_events.noload_app, i_events.noload_fund, i_events.noload_total};
  ////////////////////////////////////////////////////////////////////////
  // Shadow of the enable register
  always_comb begin
    nxt_en = en_ff;
    if (wr_ack && i_apb.paddr == {14'h0000, memi_pkg::IDX_ENABLE, 2'h0}) begin
      nxt_en = i_apb.pwdata;
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      en_ff <= 32'h0000_0000;
    end else begin
      en_ff <= nxt_en;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  sequence s_setup;
    i_apb.psel && !i_apb.penable;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> o_apb.pready) else $error("no ready after setup");
  a_ready_one_cycle: assert property (o_apb.pready |=> !o_apb.pready) else $error("ready too long");
  a_err_with_ready: assert property (o_apb.pslverr |-> o_apb.pready) else $error("error without ready");
  a_idle_rdata_zero: assert property (!o_apb.pready |-> o_apb.prdata == 32'h0) else $error("stray read data");
  a_enable_readback: assert property (rd_en |-> o_apb.prdata == (en_ff & memi_pkg::ENABLE_MASK))
    else $error("enable readback wrong");
  a_phase_reserved: assert property (rd_ph |-> (o_apb.prdata & ~{16'h0, memi_pkg::PHASE_MASK}) == 32'h0)
    else $error("phase reserved bits set");
  a_event_irq: assert property ((|(ev & (en_ff | memi_pkg::ALWAYS_ON))) && !wr_ack |=> !o_irq_n)
    else $error("enabled event gave no interrupt");
  a_init_unmaskable: assert property (i_events.init_complete |=> !o_irq_n)
    else $error("init event masked");
  a_irq_held: assert property ($rose(o_irq_n) |-> $past(wr_ack) || $past(wr_ack, 2))
    else $error("interrupt dropped without write");
endmodule // memi_sva
bind memi_top memi_sva memi_sva_i (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_apb(i_apb), .o_apb(o_apb),
  .i_events(i_events), .i_neutral(i_neutral), .o_irq_n(o_irq_n));

// file: tb/memi_host.sv
// Host model that counts interrupt requests, one per falling edge of the line
`timescale 1ns/1ps
module memi_host (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // Interrupt line
  input wire logic i_irq_n,
  output int unsigned o_irq_seen
);
  logic irq_n_ff;
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_n_ff <= 1'b1;
      o_irq_seen <= 0;
    end else begin
      irq_n_ff <= i_irq_n;
      if (irq_n_ff && !i_irq_n) begin
        o_irq_seen <= o_irq_seen + 1;
      end
    end
  end
endmodule // memi_host

// file: tb/metering_event_interrupt_mask_tb.sv
// Register and event tests for the event mask block
`timescale 1ns/1ps
module metering_event_interrupt_mask_tb;
  logic i_clk_sys, i_resetn, o_irq_n, err;
  memi_pkg::memi_apb_req_t apb_req;
  memi_pkg::memi_apb_rsp_t apb_rsp;
  memi_pkg::memi_events_t ev;
  memi_pkg::memi_neutral_t nt;
  logic [31:0] rd, ph;
  int unsigned fails, total_checks, irq_seen;
  logic [15:0] regs [4] = '{memi_pkg::IDX_ENABLE, memi_pkg::IDX_PHASE, memi_pkg::IDX_FLAGS, memi_pkg::IDX_LIMIT};
  memi_top memi_top_i (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_apb(apb_req), .o_apb(apb_rsp),
    .i_events(ev), .i_neutral(nt), .o_irq_n(o_irq_n));
  memi_host memi_host_i (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_irq_n(o_irq_n), .o_irq_seen(irq_seen));
  initial begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////
  task conclude;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    apb_req <= '{1'b1, 1'b0, wr, {14'h0000, idx, 2'h0}, wd};
    @(posedge i_clk_sys);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      conclude();
    end else begin
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req <= '0;
    end
  endtask
  task pulse(input memi_pkg::memi_events_t e);
    @(posedge i_clk_sys);
    ev <= e;
    @(posedge i_clk_sys);
    ev <= '0;
  endtask
  task neutral(input logic [27:0] s, input logic [27:0] n);
    @(posedge i_clk_sys);
    nt <= '{1'b1, s, n};
    @(posedge i_clk_sys);
    nt.valid <= 1'b0;
  endtask
  function automatic memi_pkg::memi_events_t ev_of(input int b);
    memi_pkg::memi_events_t e;
    e = '0;
    case (b)
      0: e.noload_total = 1'b1;
      1: e.noload_fund = 1'b1;
      2: e.noload_app = 1'b1;
      15: e.init_complete = 1'b1;
      16: e.dip[1] = 1'b1;
      17: e.exc_curr[0] = 1'b1;
      18: e.exc_volt[2] = 1'b1;
      19: e.volt_rise[0] = 1'b1;
      23: e.peak_curr_end = 1'b1;
      24: e.peak_volt_end = 1'b1;
      default: case ((b - 3) / 3)
        0: e.miss_volt[(b - 3) % 3] = 1'b1;
        1: e.miss_curr[(b - 3) % 3] = 1'b1;
        2: e.cross_volt[(b - 3) % 3] = 1'b1;
        default: e.cross_curr[(b - 3) % 3] = 1'b1;
      endcase
    endcase
    return e;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  initial begin
    i_resetn = 1'b0;
    apb_req = '0;
    ev = '0;
    nt = '0;
    repeat (8) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    foreach (regs[k]) begin
      apb(1'b0, regs[k], 32'h0);
      chk(rd, 32'h0);
    end
    chk({31'h0, o_irq_n}, 32'h1);
    apb(1'b1, memi_pkg::IDX_ENABLE, 32'hFFFF_FFFF);
    apb(1'b0, memi_pkg::IDX_ENABLE, 32'h0);
    chk(rd, memi_pkg::ENABLE_MASK);
    apb(1'b1, memi_pkg::IDX_PHASE, 32'hFFFF_FFFF);
    apb(1'b0, memi_pkg::IDX_PHASE, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 16'h0001, 32'h0);
    chk({err, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, memi_pkg::IDX_LIMIT, 32'h0000_00C8);
    neutral(28'h64, 28'h0A);
    pulse(ev_of(19));
    pulse(memi_pkg::memi_events_t'(30'h0000_0008));
    apb(1'b0, memi_pkg::IDX_FLAGS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, memi_pkg::IDX_LIMIT, 32'h0000_0032);
    $display("register tests done");
    for (int b = 0; b < 25; b++) begin
      if (b == 21 || b == 22) continue;
      apb(1'b1, memi_pkg::IDX_ENABLE, 32'h0);
      if (b == 20) neutral(28'h64, 28'h0A);
      else pulse(ev_of(b));
      if (b == 19) pulse(memi_pkg::memi_events_t'(30'h0000_0010));
      repeat (3) @(posedge i_clk_sys);
      chk({31'h0, o_irq_n}, {31'h0, b != 15});
      apb(1'b1, memi_pkg::IDX_ENABLE, 32'h1 << b);
      repeat (2) @(posedge i_clk_sys);
      chk({31'h0, o_irq_n}, 32'h0);
      if (b >= 16 && b <= 18) begin
        ph = (b == 16) ? 32'h2000 : (b == 17) ? 32'h0008 : 32'h0800;
        apb(1'b0, memi_pkg::IDX_PHASE, 32'h0);
        chk(rd, ph);
      end
      apb(1'b1, memi_pkg::IDX_FLAGS, 32'h1 << b);
      repeat (2) @(posedge i_clk_sys);
      chk({31'h0, o_irq_n}, 32'h1);
    end
    chk({31'h0, irq_seen == 23}, 32'h1);
    $display("event tests done");
    conclude();
  end
endmodule // metering_event_interrupt_mask_tb
